// >>> core/emt_pkg.sv
package emt_pkg;

   // register byte addresses on the 32-bit bus
   localparam logic [7:0] A_MSR_LO = 8'h00;
   localparam logic [7:0] A_MSR_HI = 8'h04;
   localparam logic [7:0] A_SPC_LO = 8'h08;
   localparam logic [7:0] A_SPC_HI = 8'h0C;
   localparam logic [7:0] A_SST_LO = 8'h10;
   localparam logic [7:0] A_SST_HI = 8'h14;
   localparam logic [7:0] A_DFC = 8'h18;
   localparam logic [7:0] A_DFA_LO = 8'h1C;
   localparam logic [7:0] A_DFA_HI = 8'h20;
   localparam logic [7:0] A_STAT = 8'h24;

   // machine state bit positions, bit 0 of the word is the lsb
   localparam int MSR_SF = 63;
   localparam int MSR_POW = 18;
   localparam int MSR_ILE = 16;
   localparam int MSR_EE = 15;
   localparam int MSR_PR = 14;
   localparam int MSR_FP = 13;
   localparam int MSR_ME = 12;
   localparam int MSR_FE0 = 11;
   localparam int MSR_SE = 10;
   localparam int MSR_BE = 9;
   localparam int MSR_FE1 = 8;
   localparam int MSR_IR = 5;
   localparam int MSR_DR = 4;
   localparam int MSR_PMM = 2;
   localparam int MSR_RI = 1;
   localparam int MSR_LE = 0;

   // saved-status keeps state bits 48-55, 57-59, 62-63; 42-47 zero
   localparam logic [63:0] SST_KEEP = 64'h0000_0000_0000_FF73;
   localparam logic [63:0] MSR_RESET = 64'h8000_0000_0000_0000;

   // fetch targets after entry
   localparam logic [63:0] VEC_EXT = 64'h0000_0000_0000_0500;
   localparam logic [63:0] VEC_ALIGN = 64'h0000_0000_0000_0600;

   localparam logic [12:0] PAGE_BYTES = 13'h1000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // alignment cause bits, as reported in the fault-cause word
   localparam int C_FLOAT = 0;
   localparam int C_ATOMIC = 1;
   localparam int C_LE_SINGLE = 2;
   localparam int C_MULT_ATTR = 3;
   localparam int C_MULT_CROSS = 4;
   localparam int C_WTCI_MIS = 5;
   localparam int C_WTCI_OP = 6;
   localparam int NCAUSE = 7;

   typedef enum logic [1:0] {
      TR_EXT = 2'h1,
      TR_ALIGN = 2'h2
   } emt_cause_e;

   // one instruction boundary from the pipeline
   typedef struct packed {
      logic valid;
      logic higher_exc;
      logic [63:0] pc;
      logic [63:0] next_pc;
      logic mem;
      logic is_float;
      logic is_single;
      logic is_multiple;
      logic is_string;
      logic is_reserve;
      logic is_cond_store;
      logic is_ext_ctl;
      logic is_dcbz;
      logic [7:0] len;
      logic [63:0] ea;
      logic wt_required;
      logic cache_inhibit;
      logic seg_cross;
      logic attr_differ;
   } emt_instr_s;

   // redirect to the pipeline
   typedef struct packed {
      logic valid;
      emt_cause_e cause;
      logic [63:0] target;
   } emt_trap_s;

   typedef enum logic [1:0] {
      WR_IDLE = 2'h1,
      WR_RESP = 2'h2
   } emt_wr_e;

endpackage

// >>> core/emt_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser, output moves once stages two and three agree
module emt_sync (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic pin,
   output logic level_q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // capture chain
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // agreed level
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         level_q <= 1'b0;
      end else if (s2_q == s3_q) begin
         level_q <= s3_q;
      end
   end
endmodule

// >>> core/emt_trap.sv
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module emt_trap (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic ext_irq,
   input wire emt_pkg::emt_instr_s instr,
   output emt_pkg::emt_trap_s trap_q,
   output logic [63:0] machine_state_q,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic irq_level;
   logic [63:0] saved_pc_q;
   logic [63:0] saved_status_q;
   logic [31:0] fault_cause_q;
   logic [63:0] fault_addr_q;
   logic [emt_pkg::NCAUSE-1:0] acause;
   logic take_align;
   logic take_ext;
   logic [63:0] msr_entry;

   // byte-enable merge of a bus write into a word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   // operand spans a 4-Kbyte page
   function automatic logic page_cross(input logic [63:0] ea,
                                       input logic [7:0] len);
      logic [12:0] last;
      last = {1'b0, ea[11:0]} + {5'h00, len};
      return last > emt_pkg::PAGE_BYTES;
   endfunction

   // operand not on a natural boundary of its length
   function automatic logic misal(input logic [63:0] ea,
                                  input logic [7:0] len);
      logic [7:0] m;
      m = len - 8'h01;
      return (ea[7:0] & m) != 8'h00;
   endfunction

   // level from the interrupt controller, synchronised
   emt_sync u_irq_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin(ext_irq),
      .level_q(irq_level)
   );

   // alignment cause decode for the instruction at this boundary
   always_comb begin
      logic wtci;
      logic le;
      logic xl;
      logic mis;
      logic word_mis;
      wtci = instr.wt_required | instr.cache_inhibit;
      le = machine_state_q[emt_pkg::MSR_LE];
      // domains exist only with translation on
      xl = machine_state_q[emt_pkg::MSR_DR];
      mis = misal(instr.ea, instr.len);
      word_mis = instr.ea[1:0] != 2'h0;
      acause = '0;
      acause[emt_pkg::C_FLOAT] = instr.is_float &
         (word_mis | (xl & page_cross(instr.ea, instr.len)));
      acause[emt_pkg::C_ATOMIC] =
         ((instr.is_multiple | instr.is_ext_ctl) & word_mis) |
         ((instr.is_reserve | instr.is_cond_store) & mis);
      acause[emt_pkg::C_LE_SINGLE] = instr.is_single & mis & le;
      acause[emt_pkg::C_MULT_ATTR] =
         (instr.is_multiple | instr.is_string) & (wtci | le);
      acause[emt_pkg::C_MULT_CROSS] = instr.is_multiple & xl &
         (instr.seg_cross | instr.attr_differ);
      acause[emt_pkg::C_WTCI_MIS] = wtci &
         (((instr.is_single | instr.is_reserve | instr.is_cond_store) & mis)
         | ((instr.is_float | instr.is_multiple) & word_mis));
      // conditional stores fault here whether or not they would store
      acause[emt_pkg::C_WTCI_OP] = wtci & (instr.is_dcbz |
         instr.is_reserve | instr.is_cond_store);
      if (!instr.mem) begin
         acause = '0;
      end
   end

   // entry decision at an instruction boundary
   always_comb begin
      take_align = instr.valid & !instr.higher_exc & !trap_q.valid &
         (acause != '0);
      // level sampled each boundary, deferred while masked or outranked
      take_ext = instr.valid & irq_level & !instr.higher_exc &
         !take_align & !trap_q.valid &
         machine_state_q[emt_pkg::MSR_EE];
   end

   // forced machine state on entry
   always_comb begin
      msr_entry = machine_state_q;
      msr_entry[emt_pkg::MSR_SF] = 1'b1;
      msr_entry[emt_pkg::MSR_POW] = 1'b0;
      msr_entry[emt_pkg::MSR_EE] = 1'b0;
      msr_entry[emt_pkg::MSR_PR] = 1'b0;
      msr_entry[emt_pkg::MSR_FP] = 1'b0;
      msr_entry[emt_pkg::MSR_SE] = 1'b0;
      msr_entry[emt_pkg::MSR_BE] = 1'b0;
      msr_entry[emt_pkg::MSR_DR] = 1'b0;
      msr_entry[emt_pkg::MSR_PMM] = 1'b0;
      msr_entry[emt_pkg::MSR_FE0] = 1'b0;
      msr_entry[emt_pkg::MSR_FE1] = 1'b0;
      msr_entry[emt_pkg::MSR_RI] = 1'b0;
      msr_entry[emt_pkg::MSR_LE] = machine_state_q[emt_pkg::MSR_ILE];
   end

   // ---- bus slave ----
   emt_pkg::emt_wr_e wr_q;
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_wr;
   logic wr_hit;

   assign do_wr = (wr_q == emt_pkg::WR_IDLE) & aw_have_q & w_have_q;

   // write address and data taken in either order
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         s_axi_awready <= !aw_have_q & !(s_axi_awvalid & s_axi_awready)
            & (wr_q == emt_pkg::WR_IDLE);
         s_axi_wready <= !w_have_q & !(s_axi_wvalid & s_axi_wready)
            & (wr_q == emt_pkg::WR_IDLE);
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (do_wr) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // address decode for writes
   always_comb begin
      case (awaddr_q)
         emt_pkg::A_MSR_LO, emt_pkg::A_MSR_HI, emt_pkg::A_SPC_LO,
         emt_pkg::A_SPC_HI, emt_pkg::A_SST_LO, emt_pkg::A_SST_HI,
         emt_pkg::A_DFC, emt_pkg::A_DFA_LO, emt_pkg::A_DFA_HI,
         emt_pkg::A_STAT: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // write response state
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr_q <= emt_pkg::WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= emt_pkg::RESP_OKAY;
      end else begin
         case (wr_q)
            emt_pkg::WR_IDLE: begin
               if (do_wr) begin
                  wr_q <= emt_pkg::WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_hit ? emt_pkg::RESP_OKAY
                                        : emt_pkg::RESP_SLVERR;
               end
            end
            emt_pkg::WR_RESP: begin
               if (s_axi_bready) begin
                  wr_q <= emt_pkg::WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wr_q <= emt_pkg::WR_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // machine state: entry wins over a software write in the same cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         machine_state_q <= emt_pkg::MSR_RESET;
      end else if (take_ext | take_align) begin
         machine_state_q <= msr_entry;
      end else if (do_wr & awaddr_q == emt_pkg::A_MSR_LO) begin
         machine_state_q[31:0] <= merge(machine_state_q[31:0], wdata_q,
                                        wstrb_q);
      end else if (do_wr & awaddr_q == emt_pkg::A_MSR_HI) begin
         machine_state_q[63:32] <= merge(machine_state_q[63:32], wdata_q,
                                         wstrb_q);
      end
   end

   // saved pc and saved status
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         saved_pc_q <= 64'h0000_0000_0000_0000;
         saved_status_q <= 64'h0000_0000_0000_0000;
      end else if (take_align) begin
         saved_pc_q <= instr.pc;
         saved_status_q <= machine_state_q & emt_pkg::SST_KEEP;
      end else if (take_ext) begin
         saved_pc_q <= instr.next_pc;
         // 42-47 outside the keep mask, so they land as zero
         saved_status_q <=
            machine_state_q & emt_pkg::SST_KEEP;
      end else if (do_wr) begin
         case (awaddr_q)
            emt_pkg::A_SPC_LO:
               saved_pc_q[31:0] <= merge(saved_pc_q[31:0], wdata_q,
                                         wstrb_q);
            emt_pkg::A_SPC_HI:
               saved_pc_q[63:32] <= merge(saved_pc_q[63:32], wdata_q,
                                          wstrb_q);
            emt_pkg::A_SST_LO:
               saved_status_q[31:0] <= merge(saved_status_q[31:0],
                                             wdata_q, wstrb_q);
            emt_pkg::A_SST_HI:
               saved_status_q[63:32] <= merge(saved_status_q[63:32],
                                              wdata_q, wstrb_q);
            default: ;
         endcase
      end
   end

   // fault cause and fault address, always filled on alignment entry
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fault_cause_q <= 32'h0000_0000;
         fault_addr_q <= 64'h0000_0000_0000_0000;
      end else if (take_align) begin
         fault_cause_q <= {25'h0000000, acause};
         fault_addr_q <= instr.ea;
      end else if (do_wr) begin
         case (awaddr_q)
            emt_pkg::A_DFC:
               fault_cause_q <= merge(fault_cause_q, wdata_q, wstrb_q);
            emt_pkg::A_DFA_LO:
               fault_addr_q[31:0] <= merge(fault_addr_q[31:0], wdata_q,
                                           wstrb_q);
            emt_pkg::A_DFA_HI:
               fault_addr_q[63:32] <= merge(fault_addr_q[63:32], wdata_q,
                                            wstrb_q);
            default: ;
         endcase
      end
   end

   // redirect pulse toward fetch
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         trap_q <= '0;
      end else begin
         trap_q.valid <= take_ext | take_align;
         if (take_align) begin
            trap_q.cause <= emt_pkg::TR_ALIGN;
            trap_q.target <= emt_pkg::VEC_ALIGN;
         end else if (take_ext) begin
            trap_q.cause <= emt_pkg::TR_EXT;
            trap_q.target <= emt_pkg::VEC_EXT;
         end
      end
   end

   // read channel, one cycle from address to data
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= emt_pkg::RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= emt_pkg::RESP_OKAY;
         case (s_axi_araddr)
            emt_pkg::A_MSR_LO: s_axi_rdata <= machine_state_q[31:0];
            emt_pkg::A_MSR_HI: s_axi_rdata <= machine_state_q[63:32];
            emt_pkg::A_SPC_LO: s_axi_rdata <= saved_pc_q[31:0];
            emt_pkg::A_SPC_HI: s_axi_rdata <= saved_pc_q[63:32];
            emt_pkg::A_SST_LO: s_axi_rdata <= saved_status_q[31:0];
            emt_pkg::A_SST_HI: s_axi_rdata <= saved_status_q[63:32];
            emt_pkg::A_DFC: s_axi_rdata <= fault_cause_q;
            emt_pkg::A_DFA_LO: s_axi_rdata <= fault_addr_q[31:0];
            emt_pkg::A_DFA_HI: s_axi_rdata <= fault_addr_q[63:32];
            // live request level and instruction translation state
            emt_pkg::A_STAT: s_axi_rdata <= {30'h00000000,
               machine_state_q[emt_pkg::MSR_IR], irq_level};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= emt_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// >>> testbench/emt_irq_ctl.sv
`timescale 1ns/1ps
// interrupt controller model: request stays up until its cause is cleared
module emt_irq_ctl (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic raise,
   input wire logic clear,
   output logic irq_q
);
   // level request, never dropped by the core taking it
   always_ff @(posedge ref_clk) begin
      if (reset || clear) begin
         irq_q <= 1'b0;
      end else if (raise) begin
         irq_q <= 1'b1;
      end
   end
endmodule

// >>> testbench/emt_trap_checker.sv
`timescale 1ns/1ps
// entry and redirect checks at the trap port
module emt_trap_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input wire emt_pkg::emt_instr_s instr,
   input wire emt_pkg::emt_trap_s trap_q,
   input wire logic [63:0] machine_state_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // operand offset inside its own size, and slow memory kinds
   wire logic mis = |(instr.ea[7:0] & (instr.len - 8'h01));
   wire logic wtci = instr.wt_required | instr.cache_inhibit;
   sequence good_bnd_s;
      instr.valid && !instr.higher_exc && !trap_q.valid && instr.mem;
   endsequence
   sequence align_entry_s;
      trap_q.valid && trap_q.cause == emt_pkg::TR_ALIGN
         && trap_q.target == emt_pkg::VEC_ALIGN;
   endsequence
   ext_vector_a: assert property (
      trap_q.valid && trap_q.cause == emt_pkg::TR_EXT
         |-> trap_q.target == emt_pkg::VEC_EXT) else $error("ext vector");
   align_vector_a: assert property (
      trap_q.valid && trap_q.cause != emt_pkg::TR_EXT |-> align_entry_s)
      else $error("align vector");
   trap_pulse_a: assert property (
      trap_q.valid |=> !trap_q.valid) else $error("trap too long");
   trap_cause_a: assert property (
      trap_q.valid |-> $past(instr.valid && !instr.higher_exc))
      else $error("trap without boundary");
   ee_gate_a: assert property (
      trap_q.valid && trap_q.cause == emt_pkg::TR_EXT
         |-> $past(machine_state_q[emt_pkg::MSR_EE]))
      else $error("interrupt taken while disabled");
   force_state_a: assert property (
      trap_q.valid |-> machine_state_q[emt_pkg::MSR_SF]
         && !machine_state_q[emt_pkg::MSR_EE]
         && !machine_state_q[emt_pkg::MSR_PR]
         && !machine_state_q[emt_pkg::MSR_DR]
         && machine_state_q[emt_pkg::MSR_LE]
            == machine_state_q[emt_pkg::MSR_ILE]
         && $stable(machine_state_q[emt_pkg::MSR_ME]))
      else $error("state not forced");
   float_fault_a: assert property (
      good_bnd_s ##0 (instr.is_float && instr.ea[1:0] != 2'h0)
         |=> align_entry_s) else $error("float not trapped");
   le_single_a: assert property (
      good_bnd_s ##0 (instr.is_single && mis
         && machine_state_q[emt_pkg::MSR_LE]) |=> align_entry_s)
      else $error("little endian single not trapped");
   misalign_wtci_a: assert property (
      good_bnd_s ##0 (instr.is_single && mis && wtci) |=> align_entry_s)
      else $error("slow memory misalign not trapped");
   block_zero_a: assert property (
      good_bnd_s ##0 (instr.is_dcbz && wtci) |=> align_entry_s)
      else $error("block zero not trapped");
endmodule

bind emt_trap emt_trap_checker u_emt_trap_checker (
   .ref_clk(ref_clk),
   .reset(reset),
   .instr(instr),
   .trap_q(trap_q),
   .machine_state_q(machine_state_q)
);

// >>> testbench/ext_irq_and_misalign_trap_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   error_cnt++; $display("wrong value %s: expected %0h seen %0h", n, e, g); \
   end end
module ext_irq_and_misalign_trap_tb;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic raise = 1'b0;
   logic clear = 1'b0;
   logic ext_irq;
   emt_pkg::emt_instr_s instr = '0;
   emt_pkg::emt_trap_s trap_q;
   logic [63:0] machine_state_q;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0;
   logic [31:0] rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int error_cnt = 0;
   int samples_checked = 0;
   logic [31:0] seed = 32'h50094150;
   logic [65:0] t_q[$];
   logic [33:0] r_q[$];
   logic [1:0] b_q[$];
   logic [65:0] tv;
   logic [33:0] rv;
   logic [1:0] bv;

   emt_irq_ctl u_emt_irq_ctl (.ref_clk(ref_clk), .reset(reset),
      .raise(raise), .clear(clear), .irq_q(ext_irq));
   emt_trap u_emt_trap (.ref_clk(ref_clk), .reset(reset),
      .ext_irq(ext_irq), .instr(instr), .trap_q(trap_q),
      .machine_state_q(machine_state_q), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));

   // free-running core clock
   always #2.5 ref_clk = ~ref_clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // entry clears pow ee pr fp fe0 se be fe1 dr pmm ri, le from ile
   function automatic logic [31:0] forced(input logic [31:0] m);
      logic [31:0] f;
      f = m & ~32'h0004_EF16;
      f[emt_pkg::MSR_LE] = m[emt_pkg::MSR_ILE];
      return f;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e = emt_pkg::RESP_OKAY);
      logic ad;
      logic wd;
      ad = 0;
      wd = 0;
      b_q.push_back(e);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge ref_clk);
         if (awready && !ad) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (wready && !wd) begin
            wd = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge ref_clk); while (!bvalid);
      bready <= 1'b0;
      // one idle edge so the next call never re-raises bready in this step
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e = emt_pkg::RESP_OKAY);
      r_q.push_back({e, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge ref_clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge ref_clk); while (!rvalid);
      rready <= 1'b0;
      // one idle edge so the next call never re-raises rready in this step
      @(posedge ref_clk);
   endtask

   // one boundary for a single cycle, then idle
   task automatic bnd(input emt_pkg::emt_instr_s i);
      instr <= i;
      @(posedge ref_clk);
      instr <= '0;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic conclude();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // results come off the queues oldest first; no note means unexpected
   always @(posedge ref_clk) begin
      if (!reset) begin
         if (trap_q.valid) begin
            tv = t_q.size() ? t_q.pop_front() : 'x;
            `CHK("trap", tv, {trap_q.cause, trap_q.target})
         end
         if (rvalid && rready) begin
            rv = r_q.size() ? r_q.pop_front() : 'x;
            `CHK("read", rv, {rresp, rdata})
         end
         if (bvalid && bready) begin
            bv = b_q.size() ? b_q.pop_front() : 'x;
            `CHK("bresp", bv, bresp)
         end
      end
   end

   // hang guard
   initial begin
      repeat (6000) @(posedge ref_clk);
      error_cnt++;
      conclude();
   end

   // main sequence
   initial begin
      emt_pkg::emt_instr_s i;
      logic [31:0] ms;
      int cb[8] = '{emt_pkg::C_FLOAT, emt_pkg::C_ATOMIC,
         emt_pkg::C_LE_SINGLE, emt_pkg::C_MULT_ATTR, emt_pkg::C_MULT_CROSS,
         emt_pkg::C_WTCI_MIS, emt_pkg::C_WTCI_OP, emt_pkg::C_WTCI_OP};
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd(emt_pkg::A_MSR_HI, 32'h8000_0000);
      rd(emt_pkg::A_MSR_LO, 32'h0);
      rd(8'h28, 32'h0, emt_pkg::RESP_SLVERR);
      wr(8'h28, rnd(), emt_pkg::RESP_SLVERR);
      raise <= 1'b1;
      @(posedge ref_clk);
      raise <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rd(emt_pkg::A_STAT, 32'h1);
      i = '0;
      i.valid = 1'b1;
      i.next_pc = {rnd(), rnd()};
      bnd(i);
      ms = rnd() & 32'h0005_FF37;
      ms[emt_pkg::MSR_EE] = 1'b1;
      wr(emt_pkg::A_MSR_LO, ms);
      rd(emt_pkg::A_STAT, {30'h0, ms[emt_pkg::MSR_IR], 1'b1});
      i.higher_exc = 1'b1;
      bnd(i);
      i.higher_exc = 1'b0;
      t_q.push_back({emt_pkg::TR_EXT, emt_pkg::VEC_EXT});
      bnd(i);
      rd(emt_pkg::A_SPC_LO, i.next_pc[31:0]);
      rd(emt_pkg::A_SPC_HI, i.next_pc[63:32]);
      rd(emt_pkg::A_SST_LO, ms & emt_pkg::SST_KEEP[31:0]);
      rd(emt_pkg::A_SST_HI, 32'h0);
      rd(emt_pkg::A_MSR_LO, forced(ms));
      rd(emt_pkg::A_STAT, {30'h0, ms[emt_pkg::MSR_IR], 1'b1});
      ms = '0;
      ms[emt_pkg::MSR_EE] = 1'b1;
      wr(emt_pkg::A_MSR_LO, ms);
      t_q.push_back({emt_pkg::TR_EXT, emt_pkg::VEC_EXT});
      bnd(i);
      clear <= 1'b1;
      @(posedge ref_clk);
      clear <= 1'b0;
      repeat (8) @(posedge ref_clk);
      wr(emt_pkg::A_MSR_LO, ms);
      bnd(i);
      rd(emt_pkg::A_STAT, 32'h0);
      for (int k = 0; k < 9; k++) begin
         i = '0;
         i.valid = 1'b1;
         i.mem = 1'b1;
         i.len = 8'h04;
         i.ea = 64'h1000;
         i.pc = {rnd(), rnd()};
         ms = '0;
         case (k)
            0: {i.is_float, i.ea[1:0]} = 3'h6;
            1: {i.is_multiple, i.ea[1:0]} = 3'h6;
            2: begin
               {i.is_single, i.ea[1:0]} = 3'h5;
               ms[emt_pkg::MSR_LE] = 1'b1;
            end
            3: {i.is_string, i.cache_inhibit} = 2'h3;
            4: begin
               {i.is_multiple, i.seg_cross} = 2'h3;
               ms[emt_pkg::MSR_DR] = 1'b1;
            end
            5: {i.is_single, i.wt_required, i.ea[1:0]} = 4'hE;
            6: {i.is_dcbz, i.cache_inhibit} = 2'h3;
            7: {i.is_cond_store, i.wt_required} = 2'h3;
            default: {i.is_multiple, i.seg_cross} = 2'h3;
         endcase
         wr(emt_pkg::A_MSR_LO, ms);
         if (k < 8) begin
            t_q.push_back({emt_pkg::TR_ALIGN, emt_pkg::VEC_ALIGN});
         end
         bnd(i);
         if (k < 8) begin
            rd(emt_pkg::A_DFC, 32'h1 << cb[k]);
            rd(emt_pkg::A_SPC_LO, i.pc[31:0]);
            rd(emt_pkg::A_DFA_LO, i.ea[31:0]);
         end
      end
      conclude();
   end
endmodule
